/* hw/fcf_defs.svh */
// Command codes, status bit positions and sizes of the command front end
`ifndef FCF_DEFS_SVH
`define FCF_DEFS_SVH
`define FCF_ADDR_W 22
`define FCF_PART_MSB 21
`define FCF_PART_LSB 18
`define FCF_NPART 16
`define FCF_BLK_MSB 21
`define FCF_BLK_LSB 15
`define FCF_NBLK 128
`define FCF_CMD_READ_ARRAY 8'hff
`define FCF_CMD_READ_STATUS 8'h70
`define FCF_CMD_READ_ID 8'h90
`define FCF_CMD_READ_QUERY 8'h98
`define FCF_CMD_CLEAR_STATUS 8'h50
`define FCF_CMD_PROGRAM 8'h40
`define FCF_CMD_PROGRAM_ALT 8'h10
`define FCF_CMD_FACTORY 8'h30
`define FCF_CMD_CONFIRM 8'hd0
`define FCF_CMD_ERASE 8'h20
`define FCF_CMD_SUSPEND 8'hb0
`define FCF_CMD_LOCK_SETUP 8'h60
`define FCF_CMD_LOCK 8'h01
`define FCF_CMD_LOCK_DOWN 8'h2f
`define FCF_CMD_PROTECT 8'hc0
`define FCF_CMD_SET_CONFIG 8'h03
`define FCF_SR_READY 7
`define FCF_SR_ERS_SUSP 6
`define FCF_SR_ERS_FAIL 5
`define FCF_SR_PRG_FAIL 4
`define FCF_SR_PRG_SUSP 2
`define FCF_SR_RESET 8'h80
`define FCF_CFG_RESET 16'hffff
`endif

/* hw/fcf_pkg.sv */
// Types shared by the command front end
`default_nettype none
package fcf_pkg;
	typedef enum logic [1:0] {
		FCF_RD_ARRAY = 2'h0,
		FCF_RD_STATUS = 2'h1,
		FCF_RD_ID = 2'h2,
		FCF_RD_QUERY = 2'h3
	} fcf_rmode_t;

	typedef enum logic [2:0] {
		FCF_ST_IDLE = 3'h0,
		FCF_ST_PRG_SETUP = 3'h1,
		FCF_ST_ERS_SETUP = 3'h2,
		FCF_ST_FAC_SETUP = 3'h3,
		FCF_ST_LCK_SETUP = 3'h4,
		FCF_ST_PRT_SETUP = 3'h5,
		FCF_ST_FACTORY = 3'h6
	} fcf_cstate_t;

	typedef enum logic [2:0] {
		FCF_OP_NONE = 3'h0,
		FCF_OP_PROGRAM = 3'h1,
		FCF_OP_ERASE = 3'h2,
		FCF_OP_PROTECT = 3'h3,
		FCF_OP_FACTORY = 3'h4
	} fcf_op_t;

	typedef struct packed {
		logic [21:0] addr;
		logic [15:0] data;
	} fcf_wr_t;

	typedef struct packed {
		logic start;
		fcf_op_t op;
		logic [21:0] addr;
		logic [15:0] data;
	} fcf_job_t;
endpackage
`default_nettype wire

/* hw/fcf_front.sv */
// Command front end: decodes bus writes, tracks read modes and status
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "fcf_defs.svh"

module fcf_front
	import fcf_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic write_n,
	input wire fcf_wr_t wr_bus,
	input wire logic [`FCF_ADDR_W-1:0] rd_addr,
	input wire logic rd_strobe,
	input wire logic [15:0] array_data,
	input wire logic [15:0] id_data,
	input wire logic [7:0] query_data,
	input wire logic op_done,
	input wire logic op_fail,
	input wire logic lockdown_enable_n,
	output fcf_job_t job_r,
	output logic op_hold_r,
	output logic [15:0] read_data_r,
	output logic [1:0] read_source_r,
	output logic [15:0] config_r,
	output logic [`FCF_NBLK-1:0] block_lock_r,
	output logic [`FCF_NBLK-1:0] block_lockdown_r,
	output logic factory_mode_r,
	output logic [7:0] status_r
);
	//////////////////////////////////////////////////////////////////////
	logic write_n_r;
	logic cmd_stb;
	fcf_rmode_t rmode_r [`FCF_NPART];
	fcf_cstate_t cst_r;
	fcf_op_t run_op_r;
	logic busy_r;
	logic susp_r;
	logic [3:0] busy_part_r;
	logic [7:0] code;
	logic [3:0] part;
	logic [3:0] rd_part;
	logic [6:0] blk;
	logic setup_ok;
	logic seq_err;
	logic start;
	fcf_op_t start_op;
	logic susp_set;
	logic susp_clr;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			write_n_r <= 1'b1;
		end else begin
			write_n_r <= write_n;
		end
	end

	// Write strobe sampled as synchronous; data taken at the rising edge
	assign cmd_stb = write_n && !write_n_r;
	assign code = wr_bus.data[7:0];
	assign part = wr_bus.addr[`FCF_PART_MSB:`FCF_PART_LSB];
	assign blk = wr_bus.addr[`FCF_BLK_MSB:`FCF_BLK_LSB];
	assign rd_part = rd_addr[`FCF_PART_MSB:`FCF_PART_LSB];

	//////////////////////////////////////////////////////////////////////
	// Second-cycle decode
	always_comb begin
		seq_err = 1'b0;
		start = 1'b0;
		start_op = FCF_OP_NONE;
		setup_ok = 1'b0;
		unique case (cst_r)
			FCF_ST_IDLE: begin
			end
			FCF_ST_PRG_SETUP: begin
				start = 1'b1;
				start_op = FCF_OP_PROGRAM;
			end
			FCF_ST_ERS_SETUP: begin
				if (code == `FCF_CMD_CONFIRM) begin
					start = 1'b1;
					start_op = FCF_OP_ERASE;
				end else begin
					seq_err = 1'b1;
				end
			end
			FCF_ST_FAC_SETUP: begin
				if (code == `FCF_CMD_CONFIRM) begin
					setup_ok = 1'b1;
				end else begin
					seq_err = 1'b1;
				end
			end
			FCF_ST_LCK_SETUP: begin
				if (code == `FCF_CMD_LOCK || code == `FCF_CMD_CONFIRM ||
					code == `FCF_CMD_LOCK_DOWN ||
					code == `FCF_CMD_SET_CONFIG) begin
					setup_ok = 1'b1;
				end else begin
					seq_err = 1'b1;
				end
			end
			FCF_ST_PRT_SETUP: begin
				start = 1'b1;
				start_op = FCF_OP_PROTECT;
			end
			FCF_ST_FACTORY: begin
				start = 1'b1;
				start_op = FCF_OP_FACTORY;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cst_r <= FCF_ST_IDLE;
		end else if (cmd_stb) begin
			unique case (cst_r)
				FCF_ST_IDLE: begin
					if (busy_r && !susp_r) begin
						cst_r <= FCF_ST_IDLE;
					end else begin
						unique case (code)
							// One job slot: no new job beside a suspended one
							`FCF_CMD_PROGRAM, `FCF_CMD_PROGRAM_ALT:
								cst_r <= susp_r ? FCF_ST_IDLE : FCF_ST_PRG_SETUP;
							`FCF_CMD_ERASE:
								cst_r <= susp_r ? FCF_ST_IDLE : FCF_ST_ERS_SETUP;
							`FCF_CMD_FACTORY:
								cst_r <= susp_r ? FCF_ST_IDLE : FCF_ST_FAC_SETUP;
							`FCF_CMD_LOCK_SETUP:
								cst_r <= FCF_ST_LCK_SETUP;
							`FCF_CMD_PROTECT:
								cst_r <= susp_r ? FCF_ST_IDLE : FCF_ST_PRT_SETUP;
							default:
								cst_r <= FCF_ST_IDLE;
						endcase
					end
				end
				FCF_ST_FAC_SETUP:
					cst_r <= setup_ok ? FCF_ST_FACTORY : FCF_ST_IDLE;
				// Factory mode ends only by reset; each later write starts a factory job instead of being decoded
				FCF_ST_FACTORY:
					cst_r <= FCF_ST_FACTORY;
				default:
					cst_r <= FCF_ST_IDLE;
			endcase
		end
	end

	// Own flop: set with the confirm, cleared only by reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			factory_mode_r <= 1'b0;
		end else if (cmd_stb && cst_r == FCF_ST_FAC_SETUP && setup_ok) begin
			factory_mode_r <= 1'b1;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Operation hand-off to the write state machine
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			job_r <= '0;
		end else begin
			job_r.start <= cmd_stb && start;
			if (cmd_stb && start) begin
				job_r.op <= start_op;
				job_r.addr <= wr_bus.addr;
				job_r.data <= wr_bus.data;
			end
		end
	end

	// Suspend and resume; a job that ends this cycle is not suspended
	assign susp_set = cmd_stb && cst_r == FCF_ST_IDLE && busy_r && !susp_r &&
		!op_done && code == `FCF_CMD_SUSPEND &&
		run_op_r != FCF_OP_FACTORY;
	assign susp_clr = cmd_stb && cst_r == FCF_ST_IDLE && busy_r && susp_r &&
		code == `FCF_CMD_CONFIRM;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			busy_r <= 1'b0;
			run_op_r <= FCF_OP_NONE;
			busy_part_r <= '0;
		end else if (cmd_stb && start) begin
			busy_r <= 1'b1;
			run_op_r <= start_op;
			busy_part_r <= part;
		end else if (op_done && busy_r && !susp_r) begin
			busy_r <= 1'b0;
			run_op_r <= FCF_OP_NONE;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			susp_r <= 1'b0;
		end else if (susp_set) begin
			susp_r <= 1'b1;
		end else if (susp_clr) begin
			susp_r <= 1'b0;
		end
	end

	// Hold to the write state machine, kept in its own flop for the pin
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			op_hold_r <= 1'b0;
		end else if (susp_set) begin
			op_hold_r <= 1'b1;
		end else if (susp_clr) begin
			op_hold_r <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Status register; hardware sets win over the clear command
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_r <= `FCF_SR_RESET;
		end else begin
			if (cmd_stb && cst_r == FCF_ST_IDLE &&
				code == `FCF_CMD_CLEAR_STATUS && !(busy_r && !susp_r)) begin
				status_r[1] <= 1'b0;
				status_r[3] <= 1'b0;
				status_r[`FCF_SR_PRG_FAIL] <= 1'b0;
				status_r[`FCF_SR_ERS_FAIL] <= 1'b0;
			end
			if (cmd_stb && seq_err) begin
				status_r[`FCF_SR_PRG_FAIL] <= 1'b1;
				status_r[`FCF_SR_ERS_FAIL] <= 1'b1;
			end
			if (op_done && busy_r && !susp_r && op_fail) begin
				if (run_op_r == FCF_OP_ERASE) begin
					status_r[`FCF_SR_ERS_FAIL] <= 1'b1;
				end else begin
					status_r[`FCF_SR_PRG_FAIL] <= 1'b1;
				end
			end
			status_r[`FCF_SR_READY] <= !busy_r || susp_r;
			status_r[`FCF_SR_ERS_SUSP] <= susp_r && run_op_r == FCF_OP_ERASE;
			status_r[`FCF_SR_PRG_SUSP] <= susp_r && run_op_r != FCF_OP_ERASE;
			status_r[0] <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Per-partition read modes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < `FCF_NPART; i++) begin
				rmode_r[i] <= FCF_RD_ARRAY;
			end
		end else if (cmd_stb) begin
			if (seq_err || (cmd_stb && start && cst_r != FCF_ST_FACTORY)) begin
				rmode_r[part] <= FCF_RD_STATUS;
			end else if (cst_r == FCF_ST_LCK_SETUP &&
				code == `FCF_CMD_SET_CONFIG) begin
				rmode_r[part] <= FCF_RD_ARRAY;
			end else if (cst_r == FCF_ST_IDLE && !(busy_r && !susp_r &&
				part == busy_part_r && code != `FCF_CMD_READ_STATUS)) begin
				unique case (code)
					`FCF_CMD_READ_ARRAY: rmode_r[part] <= FCF_RD_ARRAY;
					`FCF_CMD_READ_STATUS: rmode_r[part] <= FCF_RD_STATUS;
					`FCF_CMD_READ_ID: rmode_r[part] <= FCF_RD_ID;
					`FCF_CMD_READ_QUERY: rmode_r[part] <= FCF_RD_QUERY;
					default: rmode_r[part] <= rmode_r[part];
				endcase
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Lock bits and configuration
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			block_lock_r <= '1;
			block_lockdown_r <= '0;
			config_r <= `FCF_CFG_RESET;
		end else if (cmd_stb && setup_ok && cst_r == FCF_ST_LCK_SETUP) begin
			unique case (code)
				`FCF_CMD_LOCK: block_lock_r[blk] <= 1'b1;
				`FCF_CMD_LOCK_DOWN: begin
					block_lock_r[blk] <= 1'b1;
					block_lockdown_r[blk] <= 1'b1;
				end
				`FCF_CMD_CONFIRM: begin
					if (!block_lockdown_r[blk] || lockdown_enable_n) begin
						block_lock_r[blk] <= 1'b0;
					end
				end
				default: config_r <= wr_bus.addr[15:0];
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Read path: any partition readable while another one works
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			read_data_r <= '0;
			read_source_r <= FCF_RD_ARRAY;
		end else if (rd_strobe) begin
			read_source_r <= rmode_r[rd_part];
			unique case (rmode_r[rd_part])
				FCF_RD_ARRAY: read_data_r <= array_data;
				FCF_RD_STATUS: read_data_r <= {8'h00, status_r};
				FCF_RD_ID: read_data_r <= id_data;
				FCF_RD_QUERY: read_data_r <= {8'h00, query_data};
			endcase
		end
	end
endmodule
`default_nettype wire

/* tb/fcf_chk.sv */
// Port checker of the command front end
`timescale 1ns/1ns
`default_nettype none
module fcf_chk
	import fcf_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic write_n,
	input wire fcf_wr_t wr_bus,
	input wire logic op_done,
	input wire fcf_job_t job_r,
	input wire logic op_hold_r,
	input wire logic [15:0] read_data_r,
	input wire logic [1:0] read_source_r,
	input wire logic [15:0] config_r,
	input wire logic factory_mode_r,
	input wire logic [7:0] status_r
);
	logic wn_r;
	logic [7:0] su_r;
	logic tk;
	logic ok;
	logic [7:0] c;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	assign c = wr_bus.data[7:0];
	assign tk = write_n & ~wn_r;
	// Busy or suspended writes are not tracked as setups
	assign ok = tk & (su_r == 8'h00) & status_r[7] & ~factory_mode_r
		& ~op_hold_r;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wn_r <= 1'b1;
			su_r <= 8'h00;
		end else begin
			wn_r <= write_n;
			if (tk)
				su_r <= (ok && c inside {8'h20, 8'h60, 8'h30, 8'h40, 8'h10,
					8'hc0}) ? c : 8'h00;
		end
	end
	a_clear_fail: assert property (ok && c == 8'h50 && !op_done |=>
		status_r[5:3] == 3'h0 && !status_r[1]) else $error("clear failed");
	a_erase_err: assert property (tk && su_r == 8'h20 && c != 8'hd0 |=>
		status_r[5:4] == 2'h3) else $error("no erase sequence error");
	a_erase_go: assert property (tk && su_r == 8'h20 && c == 8'hd0 |=>
		job_r.start && job_r.op == FCF_OP_ERASE
		&& job_r.addr == $past(wr_bus.addr) ##1 !status_r[7])
		else $error("erase bad");
	a_prog_go: assert property (tk && su_r inside {8'h40, 8'h10} |=>
		job_r.start && job_r.op == FCF_OP_PROGRAM
		&& job_r.data == $past(wr_bus.data)) else $error("program bad");
	a_cfg_load: assert property (tk && su_r == 8'h60 && c == 8'h03 |=>
		config_r == $past(wr_bus.addr[15:0])) else $error("config bad");
	a_lock_err: assert property (tk && su_r == 8'h60
		&& !(c inside {8'h01, 8'hd0, 8'h2f, 8'h03}) |=> status_r[5:4] == 2'h3)
		else $error("no lock sequence error");
	a_fact_entry: assert property (tk && su_r == 8'h30 && c == 8'hd0
		|=> factory_mode_r) else $error("factory not entered");
	a_susp_flag: assert property (tk && c == 8'hb0 && !status_r[7]
		&& !op_hold_r && !factory_mode_r |-> ##[1:4] (op_hold_r
		&& status_r[7] && (status_r[6] | status_r[2])))
		else $error("suspend not shown");
	a_status_low: assert property (read_source_r == FCF_RD_STATUS
		|-> read_data_r[15:8] == 8'h00) else $error("status high byte");
	a_start_cause: assert property (job_r.start |-> $past(tk))
		else $error("job without write");
	cover property (job_r.start && job_r.op == FCF_OP_ERASE);
	cover property (op_hold_r && status_r[7]);
	cover property (factory_mode_r);
endmodule
bind fcf_front fcf_chk fcf_chk_i (
	.clk(clk),
	.sys_rst(sys_rst),
	.write_n(write_n),
	.wr_bus(wr_bus),
	.op_done(op_done),
	.job_r(job_r),
	.op_hold_r(op_hold_r),
	.read_data_r(read_data_r),
	.read_source_r(read_source_r),
	.config_r(config_r),
	.factory_mode_r(factory_mode_r),
	.status_r(status_r)
);
`default_nettype wire

/* tb/fcf_wsm_model.sv */
// Write state machine stand-in finishing jobs after a delay
`timescale 1ns/1ns
`default_nettype none
module fcf_wsm_model
	import fcf_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire fcf_job_t job_r,
	input wire logic op_hold_r,
	input wire logic [7:0] dly,
	input wire logic fail,
	output logic op_done,
	output logic op_fail
);
	logic [7:0] cnt_r;
	// Suspend freezes the count, as the real machine pauses
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_r <= 8'h00;
			op_done <= 1'b0;
		end else begin
			op_done <= cnt_r == 8'h01 && !op_hold_r;
			if (job_r.start)
				cnt_r <= dly;
			else if (cnt_r != 8'h00 && !op_hold_r)
				cnt_r <= cnt_r - 8'h01;
		end
	end
	// Only meaningful beside done
	assign op_fail = op_done ? fail : ~fail;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench of the command front end
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import fcf_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, write_n = 1'b1, rd_strobe = 1'b0;
	logic lockdown_enable_n = 1'b1, fail = 1'b0;
	fcf_wr_t wr_bus = '0;
	logic [21:0] rd_addr = '0;
	logic [15:0] array_data = 16'h0000, id_data = 16'h0000;
	logic [7:0] query_data = 8'h00, dly = 8'h3c;
	logic op_done, op_fail, op_hold_r, factory_mode_r;
	fcf_job_t job_r;
	logic [15:0] read_data_r, config_r, r;
	logic [1:0] read_source_r;
	logic [127:0] block_lock_r, block_lockdown_r;
	logic [7:0] status_r;
	logic [31:0] seed = 32'd81132;
	int error_cnt = 0, checks_done = 0, i;
	logic [7:0] cmds [4] = '{8'h90, 8'h98, 8'h70, 8'hff};
	logic [1:0] srcs [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
	fcf_front fcf_front_i (
		.clk(clk),
		.sys_rst(sys_rst),
		.write_n(write_n),
		.wr_bus(wr_bus),
		.rd_addr(rd_addr),
		.rd_strobe(rd_strobe),
		.array_data(array_data),
		.id_data(id_data),
		.query_data(query_data),
		.op_done(op_done),
		.op_fail(op_fail),
		.lockdown_enable_n(lockdown_enable_n),
		.job_r(job_r),
		.op_hold_r(op_hold_r),
		.read_data_r(read_data_r),
		.read_source_r(read_source_r),
		.config_r(config_r),
		.block_lock_r(block_lock_r),
		.block_lockdown_r(block_lockdown_r),
		.factory_mode_r(factory_mode_r),
		.status_r(status_r)
	);
	fcf_wsm_model fcf_wsm_model_i (
		.clk(clk),
		.sys_rst(sys_rst),
		.job_r(job_r),
		.op_hold_r(op_hold_r),
		.dly(dly),
		.fail(fail),
		.op_done(op_done),
		.op_fail(op_fail)
	);
	always #2 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	function automatic logic [15:0] exp_rd(logic [1:0] s, logic [7:0] st);
		case (s)
			2'h0: return array_data;
			2'h1: return {8'h00, st};
			2'h2: return id_data;
			default: return {8'h00, query_data};
		endcase
	endfunction
	task automatic final_report();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(logic [41:0] seen, logic [41:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(logic [21:0] a, logic [15:0] d);
		write_n <= 1'b0;
		wr_bus <= '{addr: a, data: d};
		@(posedge clk);
		write_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask
	task automatic two(logic [21:0] a, logic [7:0] c1, logic [15:0] c2);
		wr(a, c1);
		wr(a, c2);
	endtask
	task automatic rd(logic [21:0] a, logic [1:0] s, logic [7:0] st);
		rd_addr <= a;
		rd_strobe <= 1'b1;
		array_data <= rnd();
		id_data <= rnd();
		query_data <= rnd();
		@(posedge clk);
		rd_strobe <= 1'b0;
		@(posedge clk);
		chk(read_source_r, s);
		chk(read_data_r, exp_rd(s, st));
	endtask
	// Waits for {suspended, ready}
	task automatic wt(logic [1:0] w);
		int n;
		for (n = 0; n < 300 && {op_hold_r, status_r[7]} !== w; n++)
			@(posedge clk);
		if (n == 300) begin
			error_cnt++;
			final_report();
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk(config_r, 16'hffff);
		rd({4'h5, 18'h0}, 2'h0, 8'h80);
		for (i = 0; i < 4; i++) begin
			wr({4'h5, rnd(), 2'h0}, cmds[i]);
			rd({4'h5, rnd(), 2'h0}, srcs[i], 8'h80);
			rd({4'h6, rnd(), 2'h0}, 2'h0, 8'h80);
		end
		wr({4'h1, 18'h0}, 8'h20);
		wr({4'h2, 18'h8000}, 8'hd0);
		rd({4'h2, 18'h0}, 2'h1, 8'h00);
		rd({4'h3, 18'h0}, 2'h0, 8'h00);
		wr({4'h2, 18'h0}, 8'h90);
		rd({4'h2, 18'h0}, 2'h1, 8'h00);
		wr(22'h0, 8'hb0);
		wt(2'b11);
		rd({4'h2, 18'h0}, 2'h1, 8'hc0);
		wr(22'h0, 8'hd0);
		wt(2'b00);
		wt(2'b01);
		rd({4'h2, 18'h0}, 2'h1, 8'h80);
		two({4'h4, 18'h0}, 8'h20, 8'hff);
		rd({4'h4, 18'h0}, 2'h1, 8'hb0);
		wr({4'h4, 18'h0}, 8'h50);
		rd({4'h4, 18'h0}, 2'h1, 8'h80);
		lockdown_enable_n <= 1'b0;
		two(22'h48000, 8'h60, 8'hd0);
		chk(block_lock_r[9], 1'b0);
		two(22'h48000, 8'h60, 8'h01);
		chk(block_lock_r[9], 1'b1);
		two(22'h48000, 8'h60, 8'h2f);
		chk(block_lockdown_r[9], 1'b1);
		two(22'h48000, 8'h60, 8'hd0);
		chk(block_lock_r[9], 1'b1);
		two(22'h48000, 8'h60, 8'h77);
		chk(status_r, 8'hb0);
		wr(22'h0, 8'h50);
		r = rnd();
		wr({6'h1c, r}, 8'h70);
		two({6'h1c, r}, 8'h60, 8'h03);
		chk(config_r, r);
		rd({6'h1c, r}, 2'h0, 8'h80);
		dly <= 8'h02;
		for (i = 0; i < 2; i++) begin
			two({4'h9, rnd(), 2'h0}, (i == 0) ? 8'h40 : 8'h10, rnd());
			wt(2'b01);
		end
		two(22'h000080, 8'hc0, 16'hfffd);
		rd(22'h000080, 2'h1, 8'h00);
		wt(2'b01);
		fail <= 1'b1;
		two({4'h9, 18'h0}, 8'h40, 16'h1234);
		wt(2'b01);
		chk(status_r, 8'h90);
		fail <= 1'b0;
		wr(22'h0, 8'h50);
		chk(status_r, 8'h80);
		two({4'h8, 18'h0}, 8'h30, 8'hd0);
		wr({4'h8, 18'h0}, 8'hff);
		chk(factory_mode_r, 1'b1);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		chk(factory_mode_r, 1'b0);
		chk(status_r, 8'h80);
		final_report();
	end
endmodule
`default_nettype wire
